// >>> design/gtb_pkg.sv
// Shared constants and types for the general-purpose timer time base
package gtb_pkg;

	localparam int unsigned CNT_W = 16;
	localparam int unsigned ADR_W = 8;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned SYNC_N = 5;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL1    = 8'h00;
	localparam logic [7:0] OFS_SMCTRL   = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_EVGEN    = 8'h0C;
	localparam logic [7:0] OFS_COUNT    = 8'h10;
	localparam logic [7:0] OFS_PRESCALE = 8'h14;
	localparam logic [7:0] OFS_RELOAD   = 8'h18;

	// Reset values
	localparam logic [15:0] RST_CTRL1    = 16'h0000;
	localparam logic [15:0] RST_SMCTRL   = 16'h0000;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [15:0] RST_PRESCALE = 16'h0000;
	localparam logic [15:0] RST_RELOAD   = 16'hFFFF;

	// Single-bit field positions
	localparam int unsigned CTRL1_CEN = 0;
	localparam int unsigned STS_UPD   = 0;
	localparam int unsigned STS_TRG   = 1;
	localparam int unsigned STS_DIR   = 2;
	localparam int unsigned EVG_UG    = 0;
	localparam int unsigned EVG_TG    = 1;

	typedef enum logic [1:0] {
		GTB_UP,
		GTB_DOWN,
		GTB_CENTER,
		GTB_CENTER_ALT
	} gtb_mode_e;

	typedef enum logic [1:0] {
		GTB_CK_CORE,
		GTB_CK_EXT1,
		GTB_CK_EXT2,
		GTB_CK_ITR
	} gtb_clk_e;

	typedef enum logic [1:0] {
		GTB_SM_OFF,
		GTB_SM_RESET,
		GTB_SM_GATED,
		GTB_SM_TRIGGER
	} gtb_slave_e;

	typedef enum logic [2:0] {
		GTB_TS_CH1,
		GTB_TS_CH2,
		GTB_TS_CH3,
		GTB_TS_CH4,
		GTB_TS_CH1_BOTH,
		GTB_TS_XTRIG,
		GTB_TS_ITR,
		GTB_TS_NONE
	} gtb_tsel_e;

	// First control register layout, bit 0 is the counter enable
	typedef struct packed {
		logic [11:0] rsv;
		logic        udis;
		gtb_mode_e   mode;
		logic        cen;
	} gtb_ctrl1_s;

	// Slave mode control register layout
	typedef struct packed {
		logic [1:0] rsv;
		gtb_slave_e smode;
		logic [1:0] xtrig_div;
		logic [3:0] filt;
		logic       pol;
		gtb_tsel_e  tsel;
		gtb_clk_e   clk_src;
	} gtb_smctrl_s;

endpackage : gtb_pkg

// >>> design/gtb_timebase.sv
// Timer time base: counter, prescaler, auto-reload, clock and trigger selection
// How it works
// - Sixteen-bit counter counting up, down or center-aligned.
// - Sixteen-bit auto-reload value bounds the count and is the reload value.
// - Prescaler divides its input by setting plus one, 1 to 65536.
// - Prescale setting is buffered; active divider loads only on update.
// - Count mode field of first control register picks up, down or center.
// - Up: from 0 add 1 per tick; at reload value wrap to 0, overrun.
// - Down: subtract 1 per tick; at 0 reload, overrun.
// - Center: count 0 up to reload value then back down, repeating.
// - Center: overrun at reload minus one going up, underrun at one going down.
// - Overrun update copies reload to shadow and prescale buffer to divider.
// - Update-disable bit suppresses update events.
// - Four clock sources: internal, external mode 1, external mode 2, trigger.
// - Internal clock feeds the prescaler when no external source is picked.
// - Mode 1 counts filtered channel edges, or both edges of channel 1.
// - Mode 2 counts external trigger after polarity, divider and filter.
// - Another timer's trigger is used unfiltered.
// - Timer can act as master and slave: reset, start, stop, clock.
// - Reset-mode measurement accepts only channel inputs 1 and 2; the code refuses only channels 3 and 4.
// - Update event on overrun, underrun and counter re-initialisation.
// - Trigger event on start, stop and internal or external trigger.
//
// The implementer's own choices: the address map and the Wishbone slave port.
module gtb_timebase (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [gtb_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [gtb_pkg::DAT_W-1:0]  wb_dat_i,
	output logic      [gtb_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                            wb_ack_o,
	input  wire logic [3:0]                 chan_i,
	input  wire logic                       external_trigger_input_i,
	input  wire logic                       itr_i,
	output logic                            update_evt_o,
	output logic                            trig_evt_o,
	output logic                            trgo_o,
	output logic      [gtb_pkg::CNT_W-1:0]  count_value_o
);

	localparam int unsigned W = gtb_pkg::CNT_W;

	// Registers
	logic [W-1:0] ctrl1_r;
	logic [W-1:0] smctrl_r;
	logic [1:0]   sts_r;
	logic [W-1:0] div_buf_r;
	logic [W-1:0] div_act_r;
	logic [W-1:0] div_cnt_r;
	logic [W-1:0] arr_r;
	logic [W-1:0] arr_sh_r;
	logic [W-1:0] cnt_r;
	logic         dir_r;
	logic [gtb_pkg::SYNC_N-1:0] sync1_r;
	logic [gtb_pkg::SYNC_N-1:0] sync2_r;
	logic         xtrig_prev_r;
	logic [2:0]   xtrig_div_r;
	logic         flt_r;
	logic         flt_q_r;
	logic [3:0]   flt_cnt_r;
	logic         itr_q_r;

	gtb_pkg::gtb_ctrl1_s  c1;
	gtb_pkg::gtb_smctrl_s sm;
	assign c1 = gtb_pkg::gtb_ctrl1_s'(ctrl1_r);
	assign sm = gtb_pkg::gtb_smctrl_s'(smctrl_r);

	// Two-stage synchronisers for the asynchronous pins; trigger pin is the top bit
	logic [gtb_pkg::SYNC_N-1:0] pins_raw;
	assign pins_raw = {external_trigger_input_i, chan_i};
	genvar gi;
	generate
		for (gi = 0; gi < gtb_pkg::SYNC_N; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= pins_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// Bus decode: a request is taken once, in the cycle before ack
	logic bus_req;
	logic bus_wr;
	logic hit_ctrl1;
	logic hit_sm;
	logic hit_sts;
	logic hit_evg;
	logic hit_cnt;
	logic hit_div;
	logic hit_arr;
	logic [W-1:0] wmask;
	logic [W-1:0] wdat;
	assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr    = bus_req & wb_we_i;
	assign hit_ctrl1 = wb_adr_i == gtb_pkg::OFS_CTRL1;
	assign hit_sm    = wb_adr_i == gtb_pkg::OFS_SMCTRL;
	assign hit_sts   = wb_adr_i == gtb_pkg::OFS_STATUS;
	assign hit_evg   = wb_adr_i == gtb_pkg::OFS_EVGEN;
	assign hit_cnt   = wb_adr_i == gtb_pkg::OFS_COUNT;
	assign hit_div   = wb_adr_i == gtb_pkg::OFS_PRESCALE;
	assign hit_arr   = wb_adr_i == gtb_pkg::OFS_RELOAD;
	assign wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat      = wb_dat_i[W-1:0];

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [15:0] nw, input logic [15:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge16

	// Event generation writes: bit set means act, nothing is stored
	logic sw_ug;
	logic sw_tg;
	logic sts_clr_upd;
	logic sts_clr_trg;
	logic wr_cnt;
	assign sw_ug = bus_wr & hit_evg & wb_sel_i[0] & wb_dat_i[gtb_pkg::EVG_UG];
	assign sw_tg = bus_wr & hit_evg & wb_sel_i[0] & wb_dat_i[gtb_pkg::EVG_TG];
	assign sts_clr_upd = bus_wr & hit_sts & wb_sel_i[0] & wb_dat_i[gtb_pkg::STS_UPD];
	assign sts_clr_trg = bus_wr & hit_sts & wb_sel_i[0] & wb_dat_i[gtb_pkg::STS_TRG];
	assign wr_cnt = bus_wr & hit_cnt;

	// External trigger: polarity, then edge divider by 1, 2, 4 or 8
	logic xtrig_pol;
	logic xtrig_divd;
	assign xtrig_pol  = sync2_r[4] ^ sm.pol;
	assign xtrig_divd = (sm.xtrig_div == 2'h0) ? xtrig_pol :
	                    (sm.xtrig_div == 2'h1) ? xtrig_div_r[0] :
	                    (sm.xtrig_div == 2'h2) ? xtrig_div_r[1] : xtrig_div_r[2];

	// Filter source: channel after polarity, or divided trigger pin
	logic [3:0] ch_pol;
	logic [1:0] ch_idx;
	logic       ext_sel;
	logic       flt_in;
	assign ch_pol  = sync2_r[3:0] ^ {4{sm.pol}};
	assign ch_idx  = (sm.tsel == gtb_pkg::GTB_TS_CH1_BOTH) ? 2'h0 : sm.tsel[1:0];
	assign ext_sel = (sm.clk_src == gtb_pkg::GTB_CK_EXT2) | (sm.tsel == gtb_pkg::GTB_TS_XTRIG);
	assign flt_in  = ext_sel ? xtrig_divd : ch_pol[ch_idx];

	// Trigger input: internal trigger bypasses the filter entirely
	logic flt_rise;
	logic flt_any;
	logic itr_rise;
	logic trgi_pulse;
	logic trgi_lvl;
	logic trgi_fall;
	logic is_itr;
	assign is_itr   = sm.tsel == gtb_pkg::GTB_TS_ITR;
	assign flt_rise = flt_r & ~flt_q_r;
	assign flt_any  = flt_r ^ flt_q_r;
	assign itr_rise = itr_i & ~itr_q_r;
	assign trgi_pulse = is_itr ? itr_rise :
	                    (sm.tsel == gtb_pkg::GTB_TS_CH1_BOTH) ? flt_any :
	                    (sm.tsel == gtb_pkg::GTB_TS_NONE) ? 1'b0 : flt_rise;
	assign trgi_lvl  = is_itr ? itr_i : flt_r;
	assign trgi_fall = is_itr ? (itr_q_r & ~itr_i) : (flt_q_r & ~flt_r);

	// Prescaler input pulse per clock source
	logic div_in;
	assign div_in = (sm.clk_src == gtb_pkg::GTB_CK_CORE) ? 1'b1 :
	                (sm.clk_src == gtb_pkg::GTB_CK_EXT1) ? trgi_pulse :
	                (sm.clk_src == gtb_pkg::GTB_CK_EXT2) ? flt_rise :
	                itr_rise;

	// Slave mode controller; reset mode refuses channels 3 and 4, any other trigger source resets
	logic tsel_meas_ok;
	logic slave_reset;
	logic trig_start;
	logic trig_hit;
	logic run;
	assign tsel_meas_ok = (sm.tsel != gtb_pkg::GTB_TS_CH3) & (sm.tsel != gtb_pkg::GTB_TS_CH4);
	assign slave_reset  = (sm.smode == gtb_pkg::GTB_SM_RESET) & trgi_pulse & tsel_meas_ok;
	assign trig_start   = (sm.smode == gtb_pkg::GTB_SM_TRIGGER) & trgi_pulse;
	assign trig_hit = sw_tg | ((sm.smode != gtb_pkg::GTB_SM_OFF) &
	                  (trgi_pulse | ((sm.smode == gtb_pkg::GTB_SM_GATED) & trgi_fall)));
	// Gated mode stops the count but keeps its value
	assign run = c1.cen & ((sm.smode != gtb_pkg::GTB_SM_GATED) | trgi_lvl);

	// Prescaler tick: one per divided period
	logic tick;
	assign tick = run & div_in & (div_cnt_r == div_act_r);

	// Counter next state per mode
	logic         reinit;
	logic         ovf;
	logic         unf;
	logic [W-1:0] cnt_nxt;
	logic         dir_nxt;
	assign reinit = sw_ug | slave_reset;

	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		ovf     = 1'b0;
		unf     = 1'b0;
		if (reinit) begin
			// The update in this same cycle loads the reload value, so count from it
			cnt_nxt = (c1.mode == gtb_pkg::GTB_DOWN) ? (c1.udis ? arr_sh_r : arr_r) : '0;
			dir_nxt = c1.mode == gtb_pkg::GTB_DOWN;
		end else if (wr_cnt) begin
			cnt_nxt = merge16(cnt_r, wdat, wmask);
		end else if (tick) begin
			case (c1.mode)
				gtb_pkg::GTB_UP: begin
					dir_nxt = 1'b0;
					ovf     = cnt_r == arr_sh_r;
					cnt_nxt = ovf ? '0 : cnt_r + 16'h0001;
				end
				gtb_pkg::GTB_DOWN: begin
					dir_nxt = 1'b1;
					ovf     = cnt_r == '0;
					cnt_nxt = ovf ? arr_sh_r : cnt_r - 16'h0001;
				end
				default: begin
					if (!dir_r) begin
						if (cnt_r >= arr_sh_r) begin
							dir_nxt = 1'b1;
							cnt_nxt = cnt_r - 16'h0001;
						end else begin
							cnt_nxt = cnt_r + 16'h0001;
						end
						ovf = cnt_r + 16'h0001 == arr_sh_r - 16'h0001;
					end else begin
						if (cnt_r == '0) begin
							dir_nxt = 1'b0;
							cnt_nxt = 16'h0001;
						end else begin
							cnt_nxt = cnt_r - 16'h0001;
						end
						unf = (cnt_r != '0) & (cnt_r - 16'h0001 == 16'h0001);
					end
				end
			endcase
		end
	end

	// Update event, suppressed by the disable bit
	logic upd_evt;
	assign upd_evt = (ovf | unf | reinit) & ~c1.udis;

	// Register next values; hardware set of a flag wins over a clear
	logic [W-1:0] ctrl1_w;
	logic [W-1:0] ctrl1_nxt;
	logic [1:0]   sts_set;
	logic [1:0]   sts_nxt;
	assign ctrl1_w   = (bus_wr & hit_ctrl1) ? merge16(ctrl1_r, wdat, wmask) : ctrl1_r;
	assign ctrl1_nxt = ctrl1_w | (16'(trig_start) << gtb_pkg::CTRL1_CEN);
	assign sts_set   = {trig_hit, upd_evt};
	assign sts_nxt   = (sts_r & ~{sts_clr_trg, sts_clr_upd}) | sts_set;

	// Read mux, unmapped addresses read zero
	logic [W-1:0] sts_view;
	logic [W-1:0] rd_val;
	assign sts_view = 16'(sts_r) | (16'(dir_r) << gtb_pkg::STS_DIR);
	assign rd_val = hit_ctrl1 ? ctrl1_r :
	                hit_sm    ? smctrl_r :
	                hit_sts   ? sts_view :
	                hit_cnt   ? cnt_r :
	                hit_div   ? div_buf_r :
	                hit_arr   ? arr_r : '0;

	// Bus answer: ack one cycle after the request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? {16'h0000, rd_val} : wb_dat_o;
		end
	end

	// Software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl1_r   <= gtb_pkg::RST_CTRL1;
			smctrl_r  <= gtb_pkg::RST_SMCTRL;
			div_buf_r <= gtb_pkg::RST_PRESCALE;
			arr_r     <= gtb_pkg::RST_RELOAD;
			sts_r     <= 2'h0;
		end else begin
			ctrl1_r   <= ctrl1_nxt;
			smctrl_r  <= (bus_wr & hit_sm) ? merge16(smctrl_r, wdat, wmask) : smctrl_r;
			div_buf_r <= (bus_wr & hit_div) ? merge16(div_buf_r, wdat, wmask) : div_buf_r;
			arr_r     <= (bus_wr & hit_arr) ? merge16(arr_r, wdat, wmask) : arr_r;
			sts_r     <= sts_nxt;
		end
	end

	// Shadow copies load only on an update event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arr_sh_r  <= gtb_pkg::RST_RELOAD;
			div_act_r <= gtb_pkg::RST_PRESCALE;
		end else if (upd_evt) begin
			arr_sh_r  <= arr_r;
			div_act_r <= div_buf_r;
		end
	end

	// Prescaler counter restarts on update so the new ratio starts clean
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_r <= '0;
		end else if (upd_evt | reinit) begin
			div_cnt_r <= '0;
		end else if (run & div_in) begin
			div_cnt_r <= tick ? '0 : div_cnt_r + 16'h0001;
		end
	end

	// Counter and direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= gtb_pkg::RST_COUNT;
			dir_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
		end
	end

	// Trigger pin divider counts rising edges after polarity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xtrig_prev_r <= 1'b0;
			xtrig_div_r  <= 3'h0;
		end else begin
			xtrig_prev_r <= xtrig_pol;
			xtrig_div_r  <= (xtrig_pol & ~xtrig_prev_r) ? xtrig_div_r + 3'h1 : xtrig_div_r;
		end
	end

	// Filter: output follows input after filt+1 stable samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_r     <= 1'b0;
			flt_q_r   <= 1'b0;
			flt_cnt_r <= 4'h0;
			itr_q_r   <= 1'b0;
		end else begin
			flt_q_r <= flt_r;
			itr_q_r <= itr_i;
			if (flt_in == flt_r) begin
				flt_cnt_r <= 4'h0;
			end else if (flt_cnt_r >= sm.filt) begin
				flt_r     <= flt_in;
				flt_cnt_r <= 4'h0;
			end else begin
				flt_cnt_r <= flt_cnt_r + 4'h1;
			end
		end
	end

	// Event outputs; update doubles as master trigger for other timers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			update_evt_o  <= 1'b0;
			trig_evt_o    <= 1'b0;
			trgo_o        <= 1'b0;
			count_value_o <= '0;
		end else begin
			update_evt_o  <= upd_evt;
			trig_evt_o    <= trig_hit;
			trgo_o        <= upd_evt;
			count_value_o <= cnt_nxt;
		end
	end

endmodule : gtb_timebase

// >>> testbench/gtb_peer.sv
// Far side model: another timer's trigger output and a toggling pin
module gtb_peer (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  wire logic slow_i,
	output logic      itr_o,
	output logic      pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] gap_r;
	// One master pulse per period; slow mode stretches the gap to test late sources
	always_ff @(posedge clk_i) begin
		if (rst_i || !go_i) begin
			gap_r <= 4'h0;
			itr_o <= 1'b0;
			pin_o <= rst_i ? 1'b0 : pin_o;
		end else begin
			gap_r <= (gap_r == (slow_i ? 4'h8 : 4'h3)) ? 4'h0 : gap_r + 4'h1;
			itr_o <= (gap_r == 4'h0);
			pin_o <= pin_o ^ (gap_r == 4'h0);
		end
	end
endmodule : gtb_peer

// >>> testbench/gtb_timebase_asserts.sv
// Port level checks of the timer time base
module gtb_timebase_asserts (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [gtb_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [gtb_pkg::DAT_W-1:0] wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      update_evt_o,
	input wire logic                      trgo_o,
	input wire logic [gtb_pkg::CNT_W-1:0] count_value_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// A request taken while the slave is idle
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence read_s(a);
		take_s ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	// Without a write the count only steps by one, wraps to zero or reloads from zero
	sequence jump_s;
		$changed(count_value_o) && !(wb_ack_o && wb_we_i) && $past(count_value_o) != 16'h0;
	endsequence
	ack_next_a: assert property (take_s |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	trgo_copy_a: assert property (trgo_o == update_evt_o)
		else $error("master trigger differs from update");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read half not zero");
	hole_read_a: assert property (take_s ##0 (!wb_we_i && wb_adr_i >= 8'h1C) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	evgen_read_a: assert property (read_s(gtb_pkg::OFS_EVGEN) |=> wb_dat_o == 32'h0)
		else $error("event register read not zero");
	count_read_a: assert property (read_s(gtb_pkg::OFS_COUNT) |=>
		wb_dat_o[15:0] == $past(count_value_o)) else $error("count read differs");
	count_step_a: assert property (jump_s |-> count_value_o == $past(count_value_o) + 16'h1 ||
		count_value_o == $past(count_value_o) - 16'h1 || count_value_o == 16'h0)
		else $error("count moved by more than one");
endmodule : gtb_timebase_asserts

bind gtb_timebase gtb_timebase_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .update_evt_o(update_evt_o), .trgo_o(trgo_o),
	.count_value_o(count_value_o));

// >>> testbench/tb.sv
// Self-checking bench for the timer time base
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp=%0h got=%0h", n, e, a); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  RA [7] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h10, 8'h0C, 8'h20};
	localparam logic [15:0] RV [7] = '{16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0};
	logic        clk_i, rst_i, cyc, stb, we, ack, upd, trg, trgo, go, slow, itr, pin, pin_d;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat;
	logic [15:0] cnt;
	int          bad_count, compares, cycles, upd_n, trg_n, rise_n, tog_n, itr_n;
	// All channel pins and the trigger pin share the model pin
	gtb_timebase DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .chan_i({4{pin}}), .external_trigger_input_i(pin), .itr_i(itr),
		.update_evt_o(upd), .trig_evt_o(trg), .trgo_o(trgo), .count_value_o(cnt));
	gtb_peer u_peer (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow), .itr_o(itr),
		.pin_o(pin));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Event tallies and the run ceiling
	always @(posedge clk_i) begin
		pin_d <= pin;
		rise_n <= rise_n + (pin & ~pin_d);
		tog_n <= tog_n + (pin ^ pin_d);
		itr_n <= itr_n + itr;
		upd_n <= upd_n + (upd === 1'b1);
		trg_n <= trg_n + (trg === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end
	// One classic cycle; request held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
			output logic [15:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		`CHK("ack", 1'b1, ack)
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, a, d, q);
	endtask : put
	// Stop, load reload and prescale, reinitialise, then start in the given mode
	task automatic setup(input int m, input int r, input int p);
		gtb_pkg::gtb_ctrl1_s c1;
		c1 = '0;
		c1.mode = gtb_pkg::gtb_mode_e'(m[1:0]);
		c1.cen = 1'b1;
		put(gtb_pkg::OFS_CTRL1, 16'h0);
		put(gtb_pkg::OFS_RELOAD, r[15:0]);
		put(gtb_pkg::OFS_PRESCALE, p[15:0]);
		put(gtb_pkg::OFS_EVGEN, 16'h1);
		put(gtb_pkg::OFS_CTRL1, c1);
	endtask : setup
	// Cycles until the next update pulse; always moves at least one edge
	task automatic wait_upd(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (upd !== 1'b1 && n < 4000);
		`CHK("update seen", 1'b1, upd)
	endtask : wait_upd
	function automatic int period(input int m, input int r, input int p);
		return (m < 2) ? (r + 1) * (p + 1) : r * (p + 1);
	endfunction : period
	function automatic int tally(input int k);
		return (k == 1) ? tog_n : (k == 3) ? itr_n : rise_n;
	endfunction : tally
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic conclude();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		logic [15:0] q;
		int r, p, c, b;
		gtb_pkg::gtb_smctrl_s sm;
		{rst_i, cyc, stb, we, go, slow} = 6'h20;
		adr = 8'h00;
		wdat = 32'h0;
		void'($urandom(71732));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, RA[i], 16'h0, q);
			`CHK("reset value", RV[i], q)
		end
		done("reset");
		// Every count mode with random reload and prescale
		for (int m = 0; m < 4; m++) begin
			r = 3 + $urandom % 10;
			p = $urandom % 3;
			setup(m, r, p);
			wait_upd(c);
			wait_upd(c);
			`CHK("period", period(m, r, p), c)
			wb(1'b0, gtb_pkg::OFS_STATUS, 16'h0, q);
			if (m < 2) `CHK("direction", m[0], q[gtb_pkg::STS_DIR])
			`CHK("update flag", 1'b1, q[gtb_pkg::STS_UPD])
		end
		done("modes");
		// New prescale and reload wait for the next update
		setup(0, 11, 0);
		wait_upd(c);
		b = cycles;
		put(gtb_pkg::OFS_PRESCALE, 16'h2);
		put(gtb_pkg::OFS_RELOAD, 16'h4);
		wait_upd(c);
		`CHK("old period", 12, cycles - b)
		wait_upd(c);
		`CHK("new period", period(0, 4, 2), c)
		put(gtb_pkg::OFS_CTRL1, 16'h0);
		q = cnt;
		repeat (20) @(posedge clk_i);
		`CHK("held count", q, cnt)
		put(gtb_pkg::OFS_CTRL1, 16'h1);
		repeat (10) @(posedge clk_i);
		`CHK("resumed", 1'b1, cnt != q)
		put(gtb_pkg::OFS_CTRL1, 16'h9);
		b = upd_n;
		repeat (40) @(posedge clk_i);
		put(gtb_pkg::OFS_CTRL1, 16'h8);
		put(gtb_pkg::OFS_COUNT, 16'h7);
		put(gtb_pkg::OFS_EVGEN, 16'h1);
		repeat (2) @(posedge clk_i);
		`CHK("reinit count", 16'h0, cnt)
		`CHK("silent updates", b, upd_n)
		put(gtb_pkg::OFS_CTRL1, 16'h0);
		put(gtb_pkg::OFS_EVGEN, 16'h1);
		repeat (2) @(posedge clk_i);
		`CHK("reinit update", b + 1, upd_n)
		done("update control");
		// Pin, both-edge, trigger pin and master timer as count sources
		for (int k = 0; k < 4; k++) begin
			sm = '0;
			sm.clk_src = gtb_pkg::gtb_clk_e'((k < 2) ? 1 : k);
			sm.tsel = gtb_pkg::gtb_tsel_e'((k == 0) ? 0 : k + 3);
			put(gtb_pkg::OFS_SMCTRL, sm);
			setup(0, 16'hFFFF, 0);
			b = tally(k);
			slow <= k[0];
			go <= 1'b1;
			repeat (80) @(posedge clk_i);
			go <= 1'b0;
			repeat (20) @(posedge clk_i);
			c = tally(k) - b;
			`CHK("source count", c[15:0], cnt)
		end
		sm = '0;
		sm.smode = gtb_pkg::GTB_SM_TRIGGER;
		sm.tsel = gtb_pkg::GTB_TS_ITR;
		put(gtb_pkg::OFS_SMCTRL, sm);
		put(gtb_pkg::OFS_CTRL1, 16'h0);
		put(gtb_pkg::OFS_EVGEN, 16'h1);
		b = trg_n;
		go <= 1'b1;
		repeat (3) @(posedge clk_i);
		go <= 1'b0;
		repeat (10) @(posedge clk_i);
		`CHK("trigger event", 1'b1, trg_n > b)
		`CHK("slave started", 1'b1, cnt != 16'h0)
		// Reset slave mode: channel 1 keeps restarting the count, channel 3 is ignored
		for (int k = 0; k < 2; k++) begin
			sm = '0;
			sm.smode = gtb_pkg::GTB_SM_RESET;
			sm.tsel = gtb_pkg::gtb_tsel_e'(k * 2);
			put(gtb_pkg::OFS_SMCTRL, sm);
			setup(0, 16'hFFFF, 0);
			go <= 1'b1;
			repeat (60) @(posedge clk_i);
			`CHK("reset source", k, cnt > 16'h0030)
			go <= 1'b0;
		end
		done("sources");
		conclude();
	end
endmodule : tb
